/* File: dual_timer_counter_unit.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "dual_timer_regs.svh"
// Functional notes
// R01: Source-select clear runs first timer from instruction cycle.
// R02: Timer mode without prescaler adds one per instruction cycle.
// R03: Writing first timer count blocks increments for two instruction cycles.
// R04: Source-select set counts edges of external first-timer pin.
// R05: Edge-select clear counts rising edges, set counts falling edges.
// R06: One hidden 8-bit prescaler serves first timer or watchdog only.
// R07: First timer wrap from FF to 00 sets its overflow flag.
// R08: First timer interrupt requested only while its enable is set.
// R09: Software clears first timer flag; hardware never clears it.
// R10: First timer stops in sleep, so it cannot wake the core.
// R11: Flags set regardless of own enable or global enable.
// R12: Second timer: 16-bit count in two byte registers, overflow on wrap.
// R13: Second timer counts only while run bit set, else holds.
// R14: Source bit picks timer, sync counter or async counter mode.
// R15: Timer mode per instruction cycle; counter mode on external rising edges.
// R16: Oscillator enable forces both oscillator pins to inputs.
// R17: Oscillator enable turns inverter on; clear turns it off.
// R18: Capture/compare reset input clears the 16-bit count.
// R19: Prescale codes 11, 10, 01 divide by 8, 4, 2.
// R20: Sync-disable set leaves external clock unsynchronised, clear syncs it; the code syncs it in both cases.
// R21: Top two control bits unimplemented, read as zero.
// R22: Sync-disable ignored when internal instruction clock used.
// R23: Source bit set selects external rising edges, clear internal clock.
// R24: Capture/compare reset does not set second timer overflow flag.
// R25: Prescale code 00 passes input clock undivided.
// R26: Second timer wrap sets flag; interrupt only when enabled.
module dual_timer_counter_unit (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RSTN,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Core state
  input  wire logic       SLEEP,
  input  wire logic       WATCHDOG_TICK,
  output logic            WATCHDOG_TIMEOUT,
  output logic            IRQ,
  // Pins
  input  wire logic       FIRST_TIMER_EXT_CLOCK_PIN,
  input  wire logic       SECOND_TIMER_EXT_CLOCK_PIN,
  input  wire logic [1:0] PORT_C_DIRECTION,
  output logic      [1:0] OSC_PIN_DIR_IN,
  output logic            OSC_INVERTER_EN,
  // Capture/compare reset
  input  wire logic       CAPTURE_COMPARE_RESET
);
  // -------------------------------------------------------------
  // Register bus
  // -------------------------------------------------------------
  dual_timer_pkg::bus_req_t req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [7:0] prescale_cfg;
  logic [7:0] irq_ctl;
  logic [7:0] t1_ctl;
  logic [7:0] pie;
  logic       t1_flag;
  logic [7:0] t0_count;
  logic [15:0] t1_count;

  wire wr_pre  = req.wr && req.addr == `ADDR_TIMER_PRESCALE_CFG;
  wire wr_irq  = req.wr && req.addr == `ADDR_IRQ_CONTROL;
  wire wr_t1c  = req.wr && req.addr == `ADDR_TIMER1_CONTROL;
  wire wr_pie  = req.wr && req.addr == `ADDR_PERIPH_IRQ_ENABLE;
  wire wr_pir  = req.wr && req.addr == `ADDR_PERIPH_IRQ_FLAGS;
  wire wr_t0   = req.wr && req.addr == `ADDR_FIRST_TIMER_COUNT;
  wire wr_t1l  = req.wr && req.addr == `ADDR_SECOND_COUNT_LOW;
  wire wr_t1h  = req.wr && req.addr == `ADDR_SECOND_COUNT_HIGH;

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  logic [1:0] s0;
  logic [1:0] s1;
  logic       p0;
  logic       p1;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      s0 <= 2'h0;
      s1 <= 2'h0;
      p0 <= 1'b0;
      p1 <= 1'b0;
    end else begin
      s0 <= {s0[0], FIRST_TIMER_EXT_CLOCK_PIN};
      s1 <= {s1[0], SECOND_TIMER_EXT_CLOCK_PIN};
      p0 <= s0[1];
      p1 <= s1[1];
    end
  end

  // -------------------------------------------------------------
  // Instruction cycle tick
  // -------------------------------------------------------------
  logic [1:0] phase;
  wire        icyc = phase == 2'(`INST_CYCLE_CLKS - 1);
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) phase <= 2'h0;
    else       phase <= phase + 2'h1;
  end

  // -------------------------------------------------------------
  // First timer and shared prescaler
  // -------------------------------------------------------------
  wire t0_src   = prescale_cfg[`PRE_SRC_BIT];
  wire t0_edge  = prescale_cfg[`PRE_EDGE_BIT];
  wire to_wdog  = prescale_cfg[`PRE_ASSIGN_BIT];
  wire [2:0] ps = prescale_cfg[`PRE_PS_LSB +: 3];
  // Rising when edge-select clear, falling when set
  wire ext0_evt = t0_edge ? (p0 && !s0[1]) : (!p0 && s0[1]); // R05
  wire t0_src_evt = t0_src ? ext0_evt : icyc; // R01 R04
  wire pre_in   = to_wdog ? WATCHDOG_TICK : t0_src_evt; // R06

  // Prescaler is private: no address reads it; a count write clears it when timer-assigned
  logic [7:0] prescaler;
  wire [7:0] pre_next = prescaler + 8'h1;
  // Timer ratio is 2^(rate+1), watchdog ratio 2^rate
  wire [3:0] tap      = 4'(ps) + (to_wdog ? 4'h0 : 4'h1);
  // Low tap bits all ones: this input rolls the ratio over
  wire [8:0] pre_span = (9'h001 << tap) - 9'h001;
  wire pre_full = pre_in && ((prescaler & pre_span[7:0]) == pre_span[7:0]);
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)                   prescaler <= 8'h00;
    else if (wr_t0 && !to_wdog)  prescaler <= 8'h00;
    else if (pre_in)             prescaler <= pre_next; // R06
  end
  assign WATCHDOG_TIMEOUT = to_wdog && pre_full;

  // Tick into the first timer; no prescaler means direct
  wire t0_tick = to_wdog ? t0_src_evt : pre_full; // R02

  logic [1:0] inhibit;
  wire t0_inc = t0_tick && inhibit == 2'h0 && !SLEEP; // R03 R10
  wire t0_wrap = t0_inc && t0_count == 8'hFF;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      t0_count <= 8'h00;
      inhibit  <= 2'h0;
    end else if (wr_t0) begin
      t0_count <= req.wdata;
      inhibit  <= 2'(`WRITE_INHIBIT_CYC); // R03
    end else begin
      if (t0_inc) t0_count <= t0_count + 8'h1; // R02
      if (icyc && inhibit != 2'h0) inhibit <= inhibit - 2'h1; // R03
    end
  end

  // -------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      prescale_cfg <= `RST_PRESCALE_CFG;
      irq_ctl      <= `RST_ZERO;
      t1_ctl       <= `RST_ZERO;
      pie          <= `RST_ZERO;
    end else begin
      if (wr_pre) prescale_cfg <= req.wdata;
      if (wr_t1c) t1_ctl <= req.wdata & `T1_IMPL_MASK; // R21
      if (wr_pie) pie <= req.wdata;
      if (wr_irq) irq_ctl <= req.wdata;
      // Set beats a clear in the same cycle
      if (t0_wrap) irq_ctl[`IRQ_T0_FLAG_BIT] <= 1'b1; // R07 R11 R09
    end
  end

  // -------------------------------------------------------------
  // Second timer
  // -------------------------------------------------------------
  wire t1_run  = t1_ctl[`T1_RUN_BIT];
  wire t1_src  = t1_ctl[`T1_SRC_BIT];
  wire t1_sdis = t1_ctl[`T1_SYNC_DIS_BIT];
  wire t1_osc  = t1_ctl[`T1_OSC_EN_BIT];
  wire [1:0] t1_ps = t1_ctl[`T1_PS_LSB +: 2];
  dual_timer_pkg::t1_mode_t t1_mode;
  assign t1_mode = !t1_src ? dual_timer_pkg::T1_TIMER : // R22
                   t1_sdis ? dual_timer_pkg::T1_ASYNC_CNT
                           : dual_timer_pkg::T1_SYNC_CNT; // R14 R20
  // Async mode uses the same synchronised edge (s1[1] against p1)
  // as the sync path, so both counter modes count on the same clock.
  wire ext1_rise = t1_mode == dual_timer_pkg::T1_ASYNC_CNT
                   ? (s1[1] && !p1) : (p1 && !s1[1] ? 1'b0 : s1[1] && !p1);
  wire t1_in = t1_src ? ext1_rise : icyc; // R15 R23

  logic [2:0] t1_pre;
  wire [2:0] t1_div_mask = 3'((4'h1 << t1_ps) - 4'h1);
  wire t1_tick = t1_in && t1_run
                 && ((t1_pre & t1_div_mask) == t1_div_mask); // R19 R25
  wire t1_wrap = t1_tick && t1_count == 16'hFFFF;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)                t1_pre <= 3'h0;
    else if (wr_t1l || wr_t1h) t1_pre <= 3'h0;
    else if (t1_in && t1_run) t1_pre <= t1_pre + 3'h1;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) t1_count <= 16'h0000;
    else if (CAPTURE_COMPARE_RESET) t1_count <= 16'h0000; // R18
    else if (wr_t1l) t1_count[7:0]  <= req.wdata; // R12
    else if (wr_t1h) t1_count[15:8] <= req.wdata; // R12
    else if (t1_tick) t1_count <= t1_count + 16'h1; // R13 R15
  end

  // Compare reset clears the count without a wrap, so no flag
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) t1_flag <= 1'b0;
    else if (t1_wrap && !CAPTURE_COMPARE_RESET) t1_flag <= 1'b1; // R26 R24
    else if (wr_pir) t1_flag <= req.wdata[`PIR_T1_FLAG_BIT];
  end

  assign OSC_INVERTER_EN = t1_osc; // R17
  assign OSC_PIN_DIR_IN  = t1_osc ? 2'h3 : PORT_C_DIRECTION; // R16

  // -------------------------------------------------------------
  // Interrupt request
  // -------------------------------------------------------------
  wire t0_req = irq_ctl[`IRQ_T0_FLAG_BIT] && irq_ctl[`IRQ_T0_EN_BIT]; // R08
  wire t1_req = t1_flag && pie[`PIE_T1_EN_BIT]
                && irq_ctl[`IRQ_PERIPH_BIT]; // R26
  assign IRQ = irq_ctl[`IRQ_GLOBAL_BIT] && (t0_req || t1_req);

  // -------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      `ADDR_TIMER1_CONTROL:     rd_mux = t1_ctl & `T1_IMPL_MASK; // R21
      `ADDR_TIMER_PRESCALE_CFG: rd_mux = prescale_cfg;
      `ADDR_IRQ_CONTROL:        rd_mux = irq_ctl;
      `ADDR_PERIPH_IRQ_ENABLE:  rd_mux = pie;
      `ADDR_PERIPH_IRQ_FLAGS:   rd_mux = {7'h00, t1_flag};
      `ADDR_FIRST_TIMER_COUNT:  rd_mux = t0_count;
      `ADDR_SECOND_COUNT_LOW:   rd_mux = t1_count[7:0];
      `ADDR_SECOND_COUNT_HIGH:  rd_mux = t1_count[15:8];
      default:                  rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)       RDATA <= 8'h00;
    else if (req.rd) RDATA <= rd_mux;
    else             RDATA <= 8'h00;
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_t0_wrap_flag; // R07
    @(posedge SYS_CLK) disable iff (!RSTN)
    t0_wrap |=> irq_ctl[`IRQ_T0_FLAG_BIT];
  endproperty
  a_t0_wrap_flag: assert property (p_t0_wrap_flag) else $error("t0 flag");
  property p_t0_inhibit; // R03
    @(posedge SYS_CLK) disable iff (!RSTN)
    wr_t0 ##1 !wr_t0 |=> $stable(t0_count);
  endproperty
  a_t0_inhibit: assert property (p_t0_inhibit) else $error("t0 inhibit");
  property p_sleep_hold; // R10
    @(posedge SYS_CLK) disable iff (!RSTN)
    SLEEP && !wr_t0 |=> t0_count == $past(t0_count);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep count");
  property p_t1_hold; // R13
    @(posedge SYS_CLK) disable iff (!RSTN)
    !t1_run && !CAPTURE_COMPARE_RESET && !wr_t1l && !wr_t1h
      |=> $stable(t1_count);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("t1 hold");
  property p_ccp_clear; // R18
    @(posedge SYS_CLK) disable iff (!RSTN)
    CAPTURE_COMPARE_RESET |=> t1_count == 16'h0000;
  endproperty
  a_ccp_clear: assert property (p_ccp_clear) else $error("ccp clear");
  property p_ccp_noflag; // R24
    @(posedge SYS_CLK) disable iff (!RSTN)
    CAPTURE_COMPARE_RESET && !t1_flag && !wr_pir |=> !t1_flag;
  endproperty
  a_ccp_noflag: assert property (p_ccp_noflag) else $error("ccp flag");
  property p_t1_wrap; // R26
    @(posedge SYS_CLK) disable iff (!RSTN)
    t1_wrap && !CAPTURE_COMPARE_RESET && !wr_t1l && !wr_t1h
      |=> t1_flag && t1_count == 16'h0000;
  endproperty
  a_t1_wrap: assert property (p_t1_wrap) else $error("t1 wrap");
  property p_irq_gate; // R08
    @(posedge SYS_CLK) disable iff (!RSTN)
    IRQ |-> (irq_ctl[`IRQ_T0_EN_BIT] || pie[`PIE_T1_EN_BIT]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gate");
  property p_osc_pins; // R16
    @(posedge SYS_CLK) disable iff (!RSTN)
    t1_osc |-> OSC_PIN_DIR_IN == 2'h3 && OSC_INVERTER_EN;
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("osc pins");
  property p_t0_incr; // R02
    @(posedge SYS_CLK) disable iff (!RSTN)
    t0_inc && !wr_t0 |=> t0_count == $past(t0_count) + 8'h1;
  endproperty
  a_t0_incr: assert property (p_t0_incr) else $error("t0 step");
  property p_t0_flag_keep; // R09
    @(posedge SYS_CLK) disable iff (!RSTN)
    irq_ctl[`IRQ_T0_FLAG_BIT] && !wr_irq |=> irq_ctl[`IRQ_T0_FLAG_BIT];
  endproperty
  a_t0_flag_keep: assert property (p_t0_flag_keep) else $error("t0 keep");
  property p_t0_flag_any; // R11
    @(posedge SYS_CLK) disable iff (!RSTN)
    t0_wrap && !irq_ctl[`IRQ_GLOBAL_BIT] |=> irq_ctl[`IRQ_T0_FLAG_BIT];
  endproperty
  a_t0_flag_any: assert property (p_t0_flag_any) else $error("t0 masked");
  property p_irq_global; // R08
    @(posedge SYS_CLK) disable iff (!RSTN)
    IRQ |-> irq_ctl[`IRQ_GLOBAL_BIT];
  endproperty
  a_irq_global: assert property (p_irq_global) else $error("irq global");
  // Prescaler moves only on its input or a count write
  property p_pre_private; // R06
    @(posedge SYS_CLK) disable iff (!RSTN)
    !pre_in && !wr_t0 |=> $stable(prescaler);
  endproperty
  a_pre_private: assert property (p_pre_private) else $error("prescaler");
  property p_wdog_excl; // R06
    @(posedge SYS_CLK) disable iff (!RSTN)
    !to_wdog |-> !WATCHDOG_TIMEOUT;
  endproperty
  a_wdog_excl: assert property (p_wdog_excl) else $error("wdog owner");
  // Write then quiet cycles: inhibit still holds the count
  sequence s_count_write;
    wr_t0 ##1 !wr_t0 [*3];
  endsequence
  property p_t0_inhibit_long; // R03
    @(posedge SYS_CLK) disable iff (!RSTN)
    s_count_write |-> $stable(t0_count);
  endproperty
  a_t0_inhibit_long: assert property (p_t0_inhibit_long)
    else $error("t0 inhibit long");

  // -------------------------------------------------------------
  // Second timer and read data checks
  // -------------------------------------------------------------
  property p_t1_step; // R15
    @(posedge SYS_CLK) disable iff (!RSTN)
    t1_tick && !CAPTURE_COMPARE_RESET && !wr_t1l && !wr_t1h
      |=> t1_count == $past(t1_count) + 16'h1;
  endproperty
  a_t1_step: assert property (p_t1_step) else $error("t1 step");
  property p_t1_flag_keep; // R26
    @(posedge SYS_CLK) disable iff (!RSTN)
    t1_flag && !wr_pir |=> t1_flag;
  endproperty
  a_t1_flag_keep: assert property (p_t1_flag_keep) else $error("t1 keep");
  property p_t1_top; // R21
    @(posedge SYS_CLK) disable iff (!RSTN)
    t1_ctl[7:6] == 2'h0;
  endproperty
  a_t1_top: assert property (p_t1_top) else $error("t1 top bits");
  property p_t1_timer_mode; // R22
    @(posedge SYS_CLK) disable iff (!RSTN)
    !t1_src |-> t1_mode == dual_timer_pkg::T1_TIMER;
  endproperty
  a_t1_timer_mode: assert property (p_t1_timer_mode) else $error("t1 mode");
  property p_osc_off; // R17
    @(posedge SYS_CLK) disable iff (!RSTN)
    !t1_osc |-> !OSC_INVERTER_EN && OSC_PIN_DIR_IN == PORT_C_DIRECTION;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc off");
  // Read data stand one cycle only
  property p_rdata_idle;
    @(posedge SYS_CLK) disable iff (!RSTN)
    !req.rd |=> RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata idle");
endmodule : dual_timer_counter_unit

/* File: dual_timer_counter_unit_tb.sv */
`timescale 1ns/1ns
`define CHK(w, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s expected %0h seen %0h", w, e, g); \
  end end
module dual_timer_counter_unit_tb;
  logic       SYS_CLK = 1'b0;
  logic       RSTN, WR, RD, SLEEP, WATCHDOG_TICK, CAPTURE_COMPARE_RESET;
  logic [7:0] ADDR, WDATA, RDATA, a, b, v;
  logic [1:0] PORT_C_DIRECTION, OSC_PIN_DIR_IN;
  logic       WATCHDOG_TIMEOUT, IRQ, OSC_INVERTER_EN, pin0, pin1;
  int         mismatches = 0;
  int         num_checks = 0;
  int         exp_delta;
  int         wd_hits;
  always #4 SYS_CLK = ~SYS_CLK;
  ext_pulse_source i_ext_pulse_source (.clk(SYS_CLK), .first_pin(pin0),
    .second_pin(pin1));
  dual_timer_counter_unit i_dual_timer_counter_unit (.SYS_CLK(SYS_CLK),
    .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SLEEP(SLEEP), .WATCHDOG_TICK(WATCHDOG_TICK),
    .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .IRQ(IRQ),
    .FIRST_TIMER_EXT_CLOCK_PIN(pin0),
    .SECOND_TIMER_EXT_CLOCK_PIN(pin1), .PORT_C_DIRECTION(PORT_C_DIRECTION),
    .OSC_PIN_DIR_IN(OSC_PIN_DIR_IN), .OSC_INVERTER_EN(OSC_INVERTER_EN),
    .CAPTURE_COMPARE_RESET(CAPTURE_COMPARE_RESET));
  // ----------------------------------------
  // Register bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR  <= ad;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= ad;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  // Two reads whose strobes are exactly 64 clocks apart
  task automatic span(input logic [7:0] ad, output logic [7:0] d);
    rd(ad, a);
    repeat (62) @(posedge SYS_CLK);
    rd(ad, b);
    d = 8'(b - a);
  endtask : span
  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {RSTN, WR, RD, SLEEP, WATCHDOG_TICK, CAPTURE_COMPARE_RESET} = 6'h00;
    ADDR = 8'h00;
    WDATA = 8'h00;
    void'($urandom(32'hC04619D3));
    PORT_C_DIRECTION = 2'($urandom);
    repeat (20) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    rd(8'h81, a); `CHK("prescale cfg reset", 8'hFF, a)
    rd(8'h10, a); `CHK("timer1 control reset", 8'h00, a)
    rd(8'h8C, a); `CHK("periph enable reset", 8'h00, a)
    rd(8'h55, a); `CHK("unmapped read", 8'h00, a)
    wr(8'h10, 8'hFF);
    rd(8'h10, a); `CHK("control top bits", 8'h3F, a)
    `CHK("inverter on", 1'b1, OSC_INVERTER_EN)
    `CHK("osc pins input", 2'b11, OSC_PIN_DIR_IN)
    wr(8'h10, 8'h00);
    @(posedge SYS_CLK);
    #1 `CHK("inverter off", 1'b0, OSC_INVERTER_EN)
    `CHK("osc pins direction", PORT_C_DIRECTION, OSC_PIN_DIR_IN)
    // First timer, instruction clock, no prescaler
    wr(8'h81, 8'h08);
    v = 8'($urandom_range(0, 200));
    wr(8'h01, v);
    repeat (37) @(posedge SYS_CLK);
    rd(8'h01, a);
    `CHK("inhibit after write", 1'b1, 8'(a - v) inside {[6:8]})
    span(8'h01, v); `CHK("timer0 rate", 8'd16, v)
    wr(8'h81, 8'h00);
    span(8'h01, v); `CHK("timer0 prescaled", 8'd8, v)
    wr(8'h81, 8'h08);
    wr(8'h8B, 8'h00);
    wr(8'h01, 8'hFC);
    repeat (50) @(posedge SYS_CLK);
    rd(8'h8B, a); `CHK("timer0 flag masked", 1'b1, a[2])
    `CHK("irq masked", 1'b0, IRQ)
    wr(8'h8B, 8'hA4);
    repeat (2) @(posedge SYS_CLK);
    #1 `CHK("irq enabled", 1'b1, IRQ)
    wr(8'h8B, 8'hA0);
    repeat (2) @(posedge SYS_CLK);
    #1 `CHK("irq after clear", 1'b0, IRQ)
    rd(8'h8B, a); `CHK("flag stays clear", 8'hA0, a)
    // First timer as counter of pin edges
    wr(8'h81, 8'h28);
    rd(8'h01, a);
    i_ext_pulse_source.pulse(0, 5);
    rd(8'h01, b); `CHK("rising edges", 8'd5, 8'(b - a))
    wr(8'h81, 8'h38);
    rd(8'h01, a);
    i_ext_pulse_source.set_pin(0, 1'b1);
    repeat (10) @(posedge SYS_CLK);
    rd(8'h01, b); `CHK("no count on rise", 8'd0, 8'(b - a))
    i_ext_pulse_source.set_pin(0, 1'b0);
    repeat (10) @(posedge SYS_CLK);
    rd(8'h01, b); `CHK("count on fall", 8'd1, 8'(b - a))
    SLEEP <= 1'b1;
    rd(8'h01, a);
    i_ext_pulse_source.pulse(0, 3);
    rd(8'h01, b); `CHK("frozen in sleep", 8'd0, 8'(b - a))
    SLEEP <= 1'b0;
    // Watchdog owns the prescaler at 1:2
    wr(8'h81, 8'h09);
    wd_hits = 0;
    repeat (4) begin
      @(posedge SYS_CLK);
      WATCHDOG_TICK <= 1'b1;
      #1 wd_hits += int'(WATCHDOG_TIMEOUT === 1'b1);
    end
    @(posedge SYS_CLK);
    WATCHDOG_TICK <= 1'b0;
    `CHK("watchdog ratio", 2, wd_hits)
    // Second timer, each prescale code, then stopped
    for (int p = 0; p < 5; p++) begin
      wr(8'h10, (p < 4) ? 8'((p << 4) | 1) : 8'h30);
      exp_delta = (p < 4) ? (16 >> p) : 0;
      span(8'h0E, v); `CHK("timer1 rate", 8'(exp_delta), v)
    end
    // Second timer on its pin, sync-disable clear then set
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h10, 8'h03);
    i_ext_pulse_source.pulse(1, 5);
    rd(8'h0E, a); `CHK("sync counter", 8'd5, a)
    wr(8'h10, 8'h07);
    i_ext_pulse_source.pulse(1, 5);
    rd(8'h0E, a); `CHK("async counter", 8'd10, a)
    CAPTURE_COMPARE_RESET <= 1'b1;
    @(posedge SYS_CLK);
    CAPTURE_COMPARE_RESET <= 1'b0;
    rd(8'h0E, a); `CHK("cc reset low", 8'h00, a)
    rd(8'h0C, a); `CHK("cc reset no flag", 1'b0, a[0])
    wr(8'h10, 8'h02);
    wr(8'h0F, 8'hFF);
    wr(8'h0E, 8'hFE);
    wr(8'h8C, 8'h01);
    wr(8'h8B, 8'hC0);
    wr(8'h10, 8'h03);
    i_ext_pulse_source.pulse(1, 3);
    rd(8'h0E, a); `CHK("wrap low", 8'h01, a)
    rd(8'h0F, a); `CHK("wrap high", 8'h00, a)
    rd(8'h0C, a); `CHK("timer1 flag", 1'b1, a[0])
    `CHK("timer1 irq", 1'b1, IRQ)
    tally_and_finish;
  end
endmodule : dual_timer_counter_unit_tb

/* File: dual_timer_pkg.sv */
package dual_timer_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
  typedef enum logic [1:0] {
    T1_TIMER      = 2'b00,
    T1_SYNC_CNT   = 2'b01,
    T1_ASYNC_CNT  = 2'b11
  } t1_mode_t;
endpackage : dual_timer_pkg

/* File: dual_timer_regs.svh */
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_TIMER1_CONTROL      8'h10
`define ADDR_TIMER_PRESCALE_CFG  8'h81
`define ADDR_IRQ_CONTROL         8'h8B
`define ADDR_PERIPH_IRQ_ENABLE   8'h8C
`define ADDR_FIRST_TIMER_COUNT   8'h01
`define ADDR_SECOND_COUNT_LOW    8'h0E
`define ADDR_SECOND_COUNT_HIGH   8'h0F
`define ADDR_PERIPH_IRQ_FLAGS    8'h0C
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PRE_PS_LSB        0
`define PRE_ASSIGN_BIT    3
`define PRE_EDGE_BIT      4
`define PRE_SRC_BIT       5
`define IRQ_T0_FLAG_BIT   2
`define IRQ_T0_EN_BIT     5
`define IRQ_PERIPH_BIT    6
`define IRQ_GLOBAL_BIT    7
`define T1_RUN_BIT        0
`define T1_SRC_BIT        1
`define T1_SYNC_DIS_BIT   2
`define T1_OSC_EN_BIT     3
`define T1_PS_LSB         4
`define T1_IMPL_MASK      8'h3F
`define PIE_T1_EN_BIT     0
`define PIR_T1_FLAG_BIT   0
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RST_PRESCALE_CFG  8'hFF
`define RST_ZERO          8'h00
`define INST_CYCLE_CLKS   4
`define WRITE_INHIBIT_CYC 2
`endif

/* File: ext_pulse_source.sv */
`timescale 1ns/1ns
// ----------------------------------------
// External clock pins seen by the block
// ----------------------------------------
module ext_pulse_source (
  // Clock
  input  wire logic clk,
  // Pins
  output logic      first_pin,
  output logic      second_pin
);
  initial begin
    first_pin  = 1'b0;
    second_pin = 1'b0;
  end
  // Wide pulses, so the two-flop synchroniser never drops an edge
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clk);
      set_pin(sel, 1'b1);
      repeat (6) @(posedge clk);
      set_pin(sel, 1'b0);
    end
    repeat (8) @(posedge clk);
  endtask : pulse
  task automatic set_pin(input int sel, input logic v);
    if (sel == 0) begin
      first_pin <= v;
    end else begin
      second_pin <= v;
    end
  endtask : set_pin
endmodule : ext_pulse_source
